// File: core/t0ps_defs.svh
`ifndef T0PS_DEFS_SVH
`define T0PS_DEFS_SVH
// mode register field positions
`define T0PS_MODE_RESET 8'h3F
`define T0PS_BIT_LOWOSC 7
`define T0PS_BIT_SPARE 6
`define T0PS_BIT_SRC 5
`define T0PS_BIT_EDGE 4
`define T0PS_BIT_ASSIGN 3
`define T0PS_RATE_HI 2
`define T0PS_RATE_LO 0
// prescaler counter resets to all ones, as its readback shows
`define T0PS_PRESC_RESET 8'hFF
`define T0PS_TMR_RESET 8'h00
`endif

// File: core/t0ps_pkg.sv
package t0ps_pkg;
  typedef struct packed {
    logic low_osc_clock_select;
    logic spare_storage_bit;
    logic timer_zero_source_select;
    logic timer_zero_edge_select;
    logic prescaler_assign;
    logic [2:0] prescaler_rate_select;
  } t0ps_mode_t;
  typedef enum logic [1:0] {T0PS_SRC_INST, T0PS_SRC_PIN, T0PS_SRC_LOWOSC} t0ps_src_t;
endpackage

// File: core/t0ps_edge_sync.sv
`include "t0ps_defs.svh"
module t0ps_edge_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic async_in,
  input wire logic falling_sel,
  output logic edge_pulse
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  wire rise_w = s2_q & ~s3_q;
  wire fall_w = ~s2_q & s3_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      edge_pulse <= falling_sel ? fall_w : rise_w;
    end
  end
endmodule

// File: core/t0ps_top.sv
// What this block does
// - mode register via dedicated instructions only
// - timer-zero rates divide 2 to 256
// - watchdog rates 1-128 reset, 2-256 interrupt
// - assign bit one routes prescaler to watchdog
// - edge bit one counts falling edges
// - same edge choice for low oscillator
// - source bit zero uses instruction clock
// - source one, lowosc zero uses pin
// - both one uses low-frequency oscillator
// - readback returns prescaler counter value
`include "t0ps_defs.svh"
module t0ps_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mode_write_instruction,
  input wire logic mode_read_instruction,
  input wire logic [7:0] mode_wdata,
  output logic [7:0] mode_rdata,
  output logic mode_rvalid,
  input wire logic external_count_input,
  input wire logic low_osc_in,
  input wire logic wdt_tick,
  input wire logic wdt_int_mode,
  input wire logic timer_zero_enable,
  input wire logic prescaler_clear,
  input wire logic readback_rd,
  output logic [7:0] prescaler_count_readback,
  output logic [7:0] timer_zero,
  output logic timer_zero_overflow,
  output logic wdt_scaled_tick
);
  // ==========================================================
  // mode register
  t0ps_pkg::t0ps_mode_t mode_q;
  t0ps_pkg::t0ps_mode_t mode_d;
  // only the dedicated instructions reach it
  assign mode_d = mode_write_instruction ? t0ps_pkg::t0ps_mode_t'(mode_wdata) : mode_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_q <= t0ps_pkg::t0ps_mode_t'(`T0PS_MODE_RESET);
    end else begin
      // spare bit stored, read back, unused
      mode_q <= mode_d;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_rdata <= 8'h00;
      mode_rvalid <= 1'b0;
    end else begin
      mode_rvalid <= mode_read_instruction;
      if (mode_read_instruction) begin
        mode_rdata <= mode_q;
      end
    end
  end
  // ==========================================================
  // source selection
  logic pin_edge;
  logic osc_edge;
  t0ps_edge_sync u_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(external_count_input),
    .falling_sel(mode_q.timer_zero_edge_select),
    .edge_pulse(pin_edge)
  );
  // low oscillator shares the edge choice
  t0ps_edge_sync u_osc_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(low_osc_in),
    .falling_sel(mode_q.timer_zero_edge_select),
    .edge_pulse(osc_edge)
  );
  function automatic t0ps_pkg::t0ps_src_t src_of(input t0ps_pkg::t0ps_mode_t m);
    if (!m.timer_zero_source_select) begin
      src_of = t0ps_pkg::T0PS_SRC_INST;
    end else if (!m.low_osc_clock_select) begin
      src_of = t0ps_pkg::T0PS_SRC_PIN;
    end else begin
      src_of = t0ps_pkg::T0PS_SRC_LOWOSC;
    end
  endfunction
  wire t0ps_pkg::t0ps_src_t src_w = src_of(mode_q);
  logic t0_tick;
  always_comb begin
    case (src_w)
      t0ps_pkg::T0PS_SRC_INST: t0_tick = 1'b1;
      t0ps_pkg::T0PS_SRC_PIN: t0_tick = pin_edge;
      t0ps_pkg::T0PS_SRC_LOWOSC: t0_tick = osc_edge;
      default: t0_tick = 1'b0;
    endcase
  end
  // ==========================================================
  // shared prescaler
  // route by assign bit
  wire to_wdt_w = mode_q.prescaler_assign;
  wire presc_in_w = to_wdt_w ? wdt_tick : (t0_tick & timer_zero_enable);
  logic [7:0] presc_q;
  logic [7:0] presc_d;
  // divisor exponent: timer and wdt interrupt use code+1, wdt reset uses code
  wire [3:0] exp_w = (to_wdt_w && !wdt_int_mode) ? {1'b0, mode_q.prescaler_rate_select}
                                                 : {1'b0, mode_q.prescaler_rate_select} + 4'h1;
  // terminal when low exp bits all ones after the step; exp 0 means every input
  wire [8:0] mask_w = 9'(((9'h001 << exp_w) - 9'h001));
  wire [7:0] presc_next_w = presc_q - 8'h01;
  // counter counts down from all ones, so a wrap of the masked bits marks a full period
  wire period_w = presc_in_w && ((presc_next_w & mask_w[7:0]) == (mask_w[7:0]));
  assign presc_d = presc_in_w ? presc_next_w : presc_q;
  always_ff @(posedge mclk) begin
    if (!rst_n || prescaler_clear) begin
      presc_q <= `T0PS_PRESC_RESET;
    end else begin
      presc_q <= presc_d;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prescaler_count_readback <= `T0PS_PRESC_RESET;
    end else if (readback_rd) begin
      prescaler_count_readback <= presc_q;
    end
  end
  // ==========================================================
  // timer zero and watchdog tick
  // timer advances once per 2^(code+1) ticks
  wire t0_step_w = !to_wdt_w && period_w;
  // watchdog divide by 2^code or 2^(code+1)
  wire wdt_step_w = to_wdt_w && period_w;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timer_zero <= `T0PS_TMR_RESET;
      timer_zero_overflow <= 1'b0;
      wdt_scaled_tick <= 1'b0;
    end else begin
      timer_zero <= t0_step_w ? timer_zero + 8'h01 : timer_zero;
      timer_zero_overflow <= t0_step_w && (timer_zero == 8'hFF);
      wdt_scaled_tick <= wdt_step_w;
    end
  end
  // ==========================================================
  // checks
  a_mode_reset_value: assert property (@(posedge mclk) $fell(rst_n) |=> mode_q == 8'h3F)
    else $error("mode register reset value wrong");
  a_mode_write_takes: assert property (@(posedge mclk) disable iff (!rst_n)
    mode_write_instruction |=> mode_q == $past(mode_wdata))
    else $error("mode write not stored");
  a_mode_read_back: assert property (@(posedge mclk) disable iff (!rst_n)
    mode_read_instruction && !mode_write_instruction |=> mode_rvalid && mode_rdata == mode_q)
    else $error("mode readback mismatch");
  a_inst_src_div2: assert property (@(posedge mclk) disable iff (!rst_n || prescaler_clear)
    !to_wdt_w && src_w == t0ps_pkg::T0PS_SRC_INST && mode_q.prescaler_rate_select == 3'h0
    && timer_zero_enable && !mode_write_instruction |-> ##0 (t0_step_w == !presc_q[0]))
    else $error("div by 2 timing wrong");
  a_wdt_reset_div1: assert property (@(posedge mclk) disable iff (!rst_n)
    to_wdt_w && !wdt_int_mode && mode_q.prescaler_rate_select == 3'h0 && wdt_tick |=> wdt_scaled_tick)
    else $error("wdt reset divide by 1 wrong");
  a_wdt_no_timer: assert property (@(posedge mclk) disable iff (!rst_n)
    to_wdt_w |=> timer_zero == $past(timer_zero))
    else $error("timer stepped while prescaler on watchdog");
  a_pin_src_gated: assert property (@(posedge mclk) disable iff (!rst_n)
    src_w == t0ps_pkg::T0PS_SRC_PIN && !to_wdt_w && !pin_edge && !prescaler_clear |=> $stable(presc_q))
    else $error("pin source select wrong");
  a_osc_src_gated: assert property (@(posedge mclk) disable iff (!rst_n)
    src_w == t0ps_pkg::T0PS_SRC_LOWOSC && !to_wdt_w && !osc_edge && !prescaler_clear |=> $stable(presc_q))
    else $error("low oscillator select wrong");
  // ==========================================================
  // counting, hold and readback checks: each qualifying timer-zero input moves the prescaler by exactly one
  a_inst_step: assert property (@(posedge mclk) disable iff (!rst_n)
    src_w == t0ps_pkg::T0PS_SRC_INST && !to_wdt_w && timer_zero_enable && !prescaler_clear
    |=> presc_q == $past(presc_q) - 8'h01)
    else $error("instruction clock step wrong");
  a_pin_step: assert property (@(posedge mclk) disable iff (!rst_n)
    src_w == t0ps_pkg::T0PS_SRC_PIN && !to_wdt_w && timer_zero_enable && pin_edge && !prescaler_clear
    |=> presc_q == $past(presc_q) - 8'h01)
    else $error("pin edge step wrong");
  a_osc_step: assert property (@(posedge mclk) disable iff (!rst_n)
    src_w == t0ps_pkg::T0PS_SRC_LOWOSC && !to_wdt_w && timer_zero_enable && osc_edge && !prescaler_clear
    |=> presc_q == $past(presc_q) - 8'h01)
    else $error("low oscillator edge step wrong");
  a_timer_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
    t0_step_w && timer_zero == 8'hFF
    |=> timer_zero_overflow && timer_zero == 8'h00)
    else $error("timer wrap or overflow wrong");
  a_timer_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !t0_step_w
    |=> $stable(timer_zero))
    else $error("timer moved without a period");
  a_wdt_int_div2: assert property (@(posedge mclk) disable iff (!rst_n)
    to_wdt_w && wdt_int_mode && mode_q.prescaler_rate_select == 3'h0 && wdt_tick
    |=> wdt_scaled_tick == !$past(presc_q[0]))
    else $error("wdt interrupt divide by 2 wrong");
  a_wdt_tick_gated: assert property (@(posedge mclk) disable iff (!rst_n)
    !wdt_step_w
    |=> !wdt_scaled_tick)
    else $error("wdt tick without a period");
  a_rvalid_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    mode_rvalid
    |-> $past(mode_read_instruction))
    else $error("read valid without read instruction");
  a_rdata_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !mode_read_instruction
    |=> $stable(mode_rdata))
    else $error("mode read data moved without read");
  a_mode_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !mode_write_instruction
    |=> $stable(mode_q))
    else $error("mode register moved without write");
  a_readback_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !readback_rd
    |=> $stable(prescaler_count_readback))
    else $error("readback moved without read");
  a_readback_value: assert property (@(posedge mclk) disable iff (!rst_n)
    readback_rd |=> prescaler_count_readback == $past(presc_q))
    else $error("prescaler readback wrong");
endmodule

// File: dv/t0ps_count_src.sv
module t0ps_count_src (
  input wire logic mclk,
  output logic pin,
  output logic losc
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pin = 1'b0;
    losc = 1'b0;
  end
  task automatic emit(input logic sel, input int n);
    repeat (n) begin
      @(posedge mclk);
      if (sel) losc <= ~losc;
      else pin <= ~pin;
      repeat (6) @(posedge mclk);
    end
  endtask
  task automatic idle();
    @(posedge mclk);
    pin <= 1'b0;
    losc <= 1'b0;
  endtask
endmodule

// File: dv/t0ps_top_tb_top.sv
module t0ps_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] m; bit im; int k; int n; int t; logic [7:0] r;} t0ps_row_t;
  logic mclk, rst_n, mode_write_instruction, mode_read_instruction, mode_rvalid;
  logic external_count_input, low_osc_in, wdt_tick, wdt_int_mode, timer_zero_enable;
  logic prescaler_clear, readback_rd, timer_zero_overflow, wdt_scaled_tick;
  logic [7:0] mode_wdata, mode_rdata, prescaler_count_readback, timer_zero, t0;
  int errors, cmp_count, wc, oc, rv;
  // k: 0 instruction clock, 1 pin toggles, 2 low oscillator toggles, 3 watchdog ticks
  t0ps_row_t rows[13] = '{
    '{8'h00, 0, 0, 8, 4, 8'hF7},
    '{8'h87, 0, 0, 512, 2, 8'hFF},
    '{8'h40, 0, 0, 8, 4, 8'hF7},
    '{8'h20, 0, 1, 3, 1, 8'hFD},
    '{8'h30, 0, 1, 3, 0, 8'hFE},
    '{8'h20, 0, 2, 3, 0, 8'hFF},
    '{8'hA0, 0, 1, 3, 0, 8'hFF},
    '{8'hA0, 0, 2, 3, 1, 8'hFD},
    '{8'hB0, 0, 2, 3, 0, 8'hFE},
    '{8'h08, 0, 3, 3, 3, 8'h00},
    '{8'h0F, 0, 3, 256, 2, 8'h00},
    '{8'h0F, 1, 3, 256, 1, 8'h00},
    '{8'h08, 1, 3, 4, 2, 8'h00}};
  t0ps_top u_t0ps_top (.mclk, .rst_n, .mode_write_instruction, .mode_read_instruction, .mode_wdata,
    .mode_rdata, .mode_rvalid, .external_count_input, .low_osc_in, .wdt_tick, .wdt_int_mode,
    .timer_zero_enable, .prescaler_clear, .readback_rd, .prescaler_count_readback, .timer_zero,
    .timer_zero_overflow, .wdt_scaled_tick);
  t0ps_count_src u_t0ps_count_src (.mclk(mclk), .pin(external_count_input), .losc(low_osc_in));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) if (wdt_scaled_tick === 1'b1) wc++;
  always @(posedge mclk) if (timer_zero_overflow === 1'b1) oc++;
  always @(posedge mclk) if (mode_rvalid === 1'b1) rv++;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic strobe(input int w, input logic [7:0] v);
    @(posedge mclk);
    mode_wdata <= v;
    mode_write_instruction <= w[0];
    mode_read_instruction <= w[1];
    readback_rd <= w[2];
    prescaler_clear <= w[3];
    @(posedge mclk);
    {mode_write_instruction, mode_read_instruction, readback_rd, prescaler_clear} <= 4'h0;
    @(posedge mclk);
    #1;
  endtask
  initial begin
    #100000;
    errors++;
    give_verdict();
  end
  // ==== sequence
  initial begin
    {rst_n, mode_write_instruction, mode_read_instruction, wdt_tick, wdt_int_mode} = 5'h00;
    {timer_zero_enable, prescaler_clear, readback_rd, mode_wdata} = 11'h000;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk(timer_zero, 8'h00);
    chk(prescaler_count_readback, 8'hFF);
    strobe(2, 8'h00);
    chk(mode_rdata, 8'h3F);
    chk(rv[7:0], 8'h01);
    strobe(3, 8'h55);
    chk(mode_rdata, 8'h3F);
    // mode is set before anything is counted
    foreach (rows[i]) begin
      strobe(1, rows[i].m);
      wdt_int_mode <= rows[i].im;
      u_t0ps_count_src.idle();
      repeat (8) @(posedge mclk);
      strobe(2, 8'h00);
      chk(mode_rdata, rows[i].m);
      strobe(8, 8'h00);
      t0 = timer_zero;
      wc = 0;
      timer_zero_enable <= (rows[i].k != 3);
      if (rows[i].k == 0) repeat (rows[i].n) @(posedge mclk);
      else if (rows[i].k < 3) u_t0ps_count_src.emit(rows[i].k == 2, rows[i].n);
      else repeat (rows[i].n) begin
        @(posedge mclk) wdt_tick <= 1'b1;
        @(posedge mclk) wdt_tick <= 1'b0;
      end
      timer_zero_enable <= 1'b0;
      repeat (8) @(posedge mclk);
      strobe(4, 8'h00);
      if (rows[i].k < 3) chk(prescaler_count_readback, rows[i].r);
      chk(rows[i].k < 3 ? timer_zero - t0 : wc[7:0], rows[i].t[7:0]);
    end
    // divide by 2 for 512 cycles: 256 steps, exactly one wrap
    strobe(1, 8'h00);
    strobe(8, 8'h00);
    t0 = timer_zero;
    oc = 0;
    timer_zero_enable <= 1'b1;
    repeat (512) @(posedge mclk);
    timer_zero_enable <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(timer_zero - t0, 8'h00);
    chk(oc[7:0], 8'h01);
    // reset in mid-run restores the mode register and the timer
    strobe(1, 8'h12);
    @(posedge mclk) rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    strobe(2, 8'h00);
    chk(mode_rdata, 8'h3F);
    chk(timer_zero, 8'h00);
    give_verdict();
  end
endmodule
